//--- core/cmbc_pkg.sv
// Purpose: shared constants for capture-move and backlash compensation
// Assumes: 200 MHz core clock, parameter port at the printed offsets
// Notes: operating mode codes are local encodings of the drive modes
package cmbc_pkg;
   // parameter offsets on the parameter port
   localparam logic [15:0] ADDR_BL_MODE = 16'h0682;
   localparam logic [15:0] ADDR_BL_AMOUNT = 16'h0684;
   localparam logic [15:0] ADDR_BL_TIME = 16'h0688;
   localparam logic [15:0] ADDR_OVT_RESP = 16'h231e;
   localparam logic [15:0] ADDR_CAP_EDGE = 16'h2320;
   // reset values, all factory defaults are zero
   localparam logic [15:0] RST_BL_MODE = 16'h0000;
   localparam logic [31:0] RST_BL_AMOUNT = 32'h0000_0000;
   localparam logic [15:0] RST_BL_TIME = 16'h0000;
   localparam logic [15:0] RST_OVT_RESP = 16'h0000;
   localparam logic [15:0] RST_CAP_EDGE = 16'h0000;
   // value ranges
   localparam logic [15:0] BL_TIME_MAX = 16'h3fff;
   localparam logic [15:0] EDGE_FALL = 16'h0000;
   localparam logic [15:0] EDGE_RISE = 16'h0001;
   localparam logic [15:0] RESP_ERR_CLASS1 = 16'h0000;
   localparam logic [15:0] RESP_NO_RETURN = 16'h0001;
   localparam logic [15:0] RESP_RETURN = 16'h0002;
   localparam logic [15:0] MODE_OFF = 16'h0000;
   localparam logic [15:0] MODE_ON_AFTER_POS_MOVE = 16'h0001;
   localparam logic [15:0] MODE_ON_AFTER_NEG_MOVE = 16'h0002;
   // operating mode codes on the mode input
   localparam logic [3:0] OPM_JOG = 4'h1;
   localparam logic [3:0] OPM_PROFILE_POS = 4'h2;
   localparam logic [3:0] OPM_INTERP_POS = 4'h3;
   localparam logic [3:0] OPM_HOMING = 4'h4;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_IN_NS = 1000000;
   localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   // divider geometry
   localparam int DIV_DW = 45;
   localparam int DIV_SW = 14;
   // take-up sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DIV = 3'b100
   } cmbc_state_e;
endpackage : cmbc_pkg

//--- core/cmbc_divider.sv
// Purpose: serial restoring divider for the backlash take-up ramp
// Assumes: divisor is nonzero whenever start is pulsed
// Notes: one quotient bit per cycle, DIV_DW cycles per result
module cmbc_divider
(
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   // request
   input wire logic start_i,
   input wire logic [cmbc_pkg::DIV_DW-1:0] dividend_i,
   input wire logic [cmbc_pkg::DIV_SW-1:0] divisor_i,
   // answer
   output logic done_o,
   output logic [31:0] quot_o
);
   logic [cmbc_pkg::DIV_DW-1:0] num_q; // shifts out dividend, shifts in quotient
   logic [cmbc_pkg::DIV_SW:0] rem_q; // partial remainder, one bit wider than divisor
   logic [5:0] cnt_q; // bits left to process
   logic busy_q;
   logic [cmbc_pkg::DIV_SW:0] trial; // remainder shifted with the next dividend bit
   logic [cmbc_pkg::DIV_SW:0] diff;

   // next remainder candidate
   always_comb
   begin
      trial = {rem_q[cmbc_pkg::DIV_SW-1:0], num_q[cmbc_pkg::DIV_DW-1]};
      diff = trial - {1'b0, divisor_i};
   end

   // iteration
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         num_q <= '0;
         rem_q <= '0;
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         done_o <= 1'b0;
         quot_o <= 32'h0000_0000;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            num_q <= dividend_i;
            rem_q <= '0;
            cnt_q <= 6'(cmbc_pkg::DIV_DW);
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            // restore when the trial subtraction would go negative
            if (trial >= {1'b0, divisor_i})
            begin
               rem_q <= diff;
               num_q <= {num_q[cmbc_pkg::DIV_DW-2:0], 1'b1};
            end
            else
            begin
               rem_q <= trial;
               num_q <= {num_q[cmbc_pkg::DIV_DW-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01)
            begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
               // last bit lands here, quotient never exceeds 31 bits
               quot_o <= {1'b0, num_q[29:0], (trial >= {1'b0, divisor_i})};
            end
         end
      end
   end
endmodule : cmbc_divider

//--- core/cmbc_top.sv
// Purpose: capture-started relative move trigger, overtravel response, backlash compensation
// Assumes: motion inputs come from core logic on the same clock, capture is a raw pin
// Notes: offset output is added by the position loop to the commanded position
//
// Contract
// RQ1 - capture edge select: 0 falling, 1 rising
// RQ2 - overshoot response: error, stop, or return
// RQ3 - overtravel response setting applies immediately
// RQ4 - detect overshoot of the relative move target
// RQ5 - backlash amount signed 32-bit, 0 to max
// RQ6 - amount and time locked while power enabled
// RQ7 - time 0 immediate, else spread over time
// RQ8 - take-up never completes before processing time
// RQ9 - mode 0 off, 1 after pos, 2 after neg
// RQ10 - controller moves once before enabling compensation
// RQ11 - that move must take up all play
// RQ12 - controller picks mode matching that direction
// RQ13 - compensation automatic on every movement while on
// RQ14 - only jog, profile pos, interp pos, homing
module cmbc_top
#(
   parameter int CYC_PER_MS = cmbc_pkg::CYC_PER_MS // clock cycles per millisecond
)
(
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   // parameter port
   input wire logic [15:0] PAR_ADDR_I,
   input wire logic [31:0] PAR_WDATA_I,
   input wire logic PAR_WR_I,
   input wire logic PAR_RD_I,
   output logic [31:0] PAR_RDATA_O,
   output logic PAR_ACK_O,
   output logic PAR_ERR_O,
   // relative move after capture
   input wire logic CAPTURE_I,
   input wire logic RELATIVE_MOVE_AFTER_CAPTURE_ENABLE_I,
   input wire logic RELATIVE_MOVE_AFTER_CAPTURE_MOVING_I,
   input wire logic [31:0] ACT_POS_I,
   input wire logic [31:0] TARGET_POS_I,
   input wire logic MOVE_DIR_POS_I,
   output logic RELATIVE_MOVE_AFTER_CAPTURE_START_O,
   output logic OVT_ERROR_O,
   output logic OVT_STOP_O,
   output logic OVT_RETURN_O,
   // backlash compensation
   input wire logic POWER_EN_I,
   input wire logic [3:0] OP_MODE_I,
   input wire logic MOTION_ACTIVE_I,
   input wire logic MOTION_DIR_POS_I,
   output logic [31:0] BL_OFFSET_O,
   output logic BL_BUSY_O
);
   // parameter registers
   logic [15:0] mode_q;
   logic [31:0] amount_q;
   logic [15:0] time_q;
   logic [15:0] resp_q;
   logic [15:0] edge_q;
   // copies active since the last power stage enable
   logic [31:0] amount_act_q;
   logic [15:0] time_act_q;
   logic pwr_q;
   // capture synchroniser, stage one feeds stage two only
   logic cap_s1_q, cap_s2_q, cap_s3_q;
   logic ovt_seen_q; // one reaction per move
   logic ovt_hit;
   // take-up sequencer
   cmbc_pkg::cmbc_state_e state_q;
   logic last_pos_q; // direction the play is taken up in
   logic goal_pos_q; // direction of the running take-up
   logic [31:0] start_off_q;
   logic [31:0] ms_cnt_q;
   logic [13:0] elapsed_q;
   logic div_start_q;
   logic div_done;
   logic [31:0] div_quot;
   logic ms_tick;
   logic comp_on, opm_ok, reversal;
   logic wr_mode, wr_amount, wr_time, wr_resp, wr_edge, wr_bad;

   // write decode with range and lock checks
   always_comb
   begin
      wr_mode = 1'b0;
      wr_amount = 1'b0;
      wr_time = 1'b0;
      wr_resp = 1'b0;
      wr_edge = 1'b0;
      wr_bad = 1'b0;
      if (PAR_WR_I)
      begin
         unique case (PAR_ADDR_I)
            cmbc_pkg::ADDR_BL_MODE:
               if (PAR_WDATA_I[15:0] <= cmbc_pkg::MODE_ON_AFTER_NEG_MOVE) wr_mode = 1'b1;
               else wr_bad = 1'b1;
            // locked while the power stage is on [RQ6]; negatives refused [RQ5]
            cmbc_pkg::ADDR_BL_AMOUNT:
               if (!POWER_EN_I && !PAR_WDATA_I[31]) wr_amount = 1'b1;
               else wr_bad = 1'b1;
            cmbc_pkg::ADDR_BL_TIME: // [RQ6] [RQ7]
               if (!POWER_EN_I && PAR_WDATA_I[15:0] <= cmbc_pkg::BL_TIME_MAX) wr_time = 1'b1;
               else wr_bad = 1'b1;
            cmbc_pkg::ADDR_OVT_RESP:
               if (PAR_WDATA_I[15:0] <= cmbc_pkg::RESP_RETURN) wr_resp = 1'b1;
               else wr_bad = 1'b1;
            cmbc_pkg::ADDR_CAP_EDGE:
               if (PAR_WDATA_I[15:0] <= cmbc_pkg::EDGE_RISE) wr_edge = 1'b1;
               else wr_bad = 1'b1;
            default: wr_bad = 1'b1; // unmapped address
         endcase
      end
   end

   // parameter storage
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         mode_q <= cmbc_pkg::RST_BL_MODE;
         amount_q <= cmbc_pkg::RST_BL_AMOUNT;
         time_q <= cmbc_pkg::RST_BL_TIME;
         resp_q <= cmbc_pkg::RST_OVT_RESP;
         edge_q <= cmbc_pkg::RST_CAP_EDGE;
      end
      else
      begin
         if (wr_mode) mode_q <= PAR_WDATA_I[15:0];
         if (wr_amount) amount_q <= PAR_WDATA_I; // [RQ5]
         if (wr_time) time_q <= PAR_WDATA_I[15:0];
         if (wr_resp) resp_q <= PAR_WDATA_I[15:0];
         if (wr_edge) edge_q <= PAR_WDATA_I[15:0];
      end
   end

   // read mux and acknowledge, one cycle after the strobe
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         PAR_RDATA_O <= 32'h0000_0000;
         PAR_ACK_O <= 1'b0;
         PAR_ERR_O <= 1'b0;
      end
      else
      begin
         PAR_ACK_O <= PAR_WR_I | PAR_RD_I;
         PAR_ERR_O <= wr_bad;
         if (PAR_RD_I && !PAR_WR_I)
         begin
            unique case (PAR_ADDR_I)
               cmbc_pkg::ADDR_BL_MODE: PAR_RDATA_O <= {16'h0000, mode_q};
               cmbc_pkg::ADDR_BL_AMOUNT: PAR_RDATA_O <= amount_q;
               cmbc_pkg::ADDR_BL_TIME: PAR_RDATA_O <= {16'h0000, time_q};
               cmbc_pkg::ADDR_OVT_RESP: PAR_RDATA_O <= {16'h0000, resp_q};
               cmbc_pkg::ADDR_CAP_EDGE: PAR_RDATA_O <= {16'h0000, edge_q};
               default:
               begin
                  PAR_RDATA_O <= 32'h0000_0000;
                  PAR_ERR_O <= 1'b1;
               end
            endcase
         end
      end
   end

   // capture pin synchroniser and edge history
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         cap_s1_q <= 1'b0;
         cap_s2_q <= 1'b0;
         cap_s3_q <= 1'b0;
      end
      else
      begin
         cap_s1_q <= CAPTURE_I;
         cap_s2_q <= cap_s1_q;
         cap_s3_q <= cap_s2_q;
      end
   end

   // start pulse on the selected edge
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I) RELATIVE_MOVE_AFTER_CAPTURE_START_O <= 1'b0;
      else if (edge_q == cmbc_pkg::EDGE_RISE)
         RELATIVE_MOVE_AFTER_CAPTURE_START_O <= RELATIVE_MOVE_AFTER_CAPTURE_ENABLE_I &&
            cap_s2_q && !cap_s3_q; // [RQ1]
      else
         RELATIVE_MOVE_AFTER_CAPTURE_START_O <= RELATIVE_MOVE_AFTER_CAPTURE_ENABLE_I &&
            !cap_s2_q && cap_s3_q; // [RQ1]
   end

   // overshoot: position passed the target in the travel direction [RQ4]
   assign ovt_hit = RELATIVE_MOVE_AFTER_CAPTURE_MOVING_I && !ovt_seen_q &&
      (MOVE_DIR_POS_I ? ($signed(ACT_POS_I) > $signed(TARGET_POS_I))
                      : ($signed(ACT_POS_I) < $signed(TARGET_POS_I)));

   // response read live, so a new setting acts on the next overshoot [RQ3]
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         ovt_seen_q <= 1'b0;
         OVT_ERROR_O <= 1'b0;
         OVT_STOP_O <= 1'b0;
         OVT_RETURN_O <= 1'b0;
      end
      else
      begin
         if (!RELATIVE_MOVE_AFTER_CAPTURE_MOVING_I) ovt_seen_q <= 1'b0;
         else if (ovt_hit) ovt_seen_q <= 1'b1; // [RQ4]
         OVT_ERROR_O <= ovt_hit && resp_q == cmbc_pkg::RESP_ERR_CLASS1; // [RQ2]
         OVT_STOP_O <= ovt_hit && resp_q == cmbc_pkg::RESP_NO_RETURN; // [RQ2]
         OVT_RETURN_O <= ovt_hit && resp_q == cmbc_pkg::RESP_RETURN; // [RQ2]
      end
   end

   // amount and time take effect at the rising power stage enable
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         pwr_q <= 1'b0;
         amount_act_q <= cmbc_pkg::RST_BL_AMOUNT;
         time_act_q <= cmbc_pkg::RST_BL_TIME;
      end
      else
      begin
         pwr_q <= POWER_EN_I;
         if (POWER_EN_I && !pwr_q)
         begin
            amount_act_q <= amount_q; // [RQ6]
            time_act_q <= time_q; // [RQ6]
         end
      end
   end

   // only the four position-type modes compensate [RQ14]
   assign opm_ok = OP_MODE_I == cmbc_pkg::OPM_JOG || OP_MODE_I == cmbc_pkg::OPM_PROFILE_POS ||
      OP_MODE_I == cmbc_pkg::OPM_INTERP_POS || OP_MODE_I == cmbc_pkg::OPM_HOMING;
   assign comp_on = mode_q != cmbc_pkg::MODE_OFF; // [RQ9]
   // any movement against the taken-up side triggers a take-up [RQ13]
   assign reversal = comp_on && opm_ok && MOTION_ACTIVE_I && MOTION_DIR_POS_I != last_pos_q;
   assign ms_tick = ms_cnt_q == 32'(CYC_PER_MS - 1);

   // take-up sequencer; a reversal during a take-up waits for its end,
   // which keeps the play model consistent at the cost of a short lag
   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RESET_N_I)
      begin
         state_q <= cmbc_pkg::ST_IDLE;
         last_pos_q <= 1'b1;
         goal_pos_q <= 1'b1;
         start_off_q <= 32'h0000_0000;
         BL_OFFSET_O <= 32'h0000_0000;
         BL_BUSY_O <= 1'b0;
         ms_cnt_q <= 32'h0000_0000;
         elapsed_q <= 14'h0000;
         div_start_q <= 1'b0;
      end
      else
      begin
         div_start_q <= 1'b0;
         if (wr_mode)
         begin
            // a mode write redefines the taken-up side at once [RQ9] [RQ12]
            state_q <= cmbc_pkg::ST_IDLE;
            last_pos_q <= PAR_WDATA_I[15:0] != cmbc_pkg::MODE_ON_AFTER_NEG_MOVE;
            BL_OFFSET_O <= 32'h0000_0000;
            BL_BUSY_O <= 1'b0;
         end
         else if (!comp_on)
         begin
            state_q <= cmbc_pkg::ST_IDLE;
            BL_OFFSET_O <= 32'h0000_0000; // [RQ9]
            BL_BUSY_O <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               cmbc_pkg::ST_IDLE:
                  if (reversal)
                  begin
                     last_pos_q <= MOTION_DIR_POS_I;
                     goal_pos_q <= MOTION_DIR_POS_I;
                     if (time_act_q == 16'h0000)
                        // zero time: whole amount in one step [RQ7]
                        BL_OFFSET_O <= MOTION_DIR_POS_I ? BL_OFFSET_O + amount_act_q
                                                        : BL_OFFSET_O - amount_act_q;
                     else
                     begin
                        start_off_q <= BL_OFFSET_O;
                        ms_cnt_q <= 32'h0000_0000;
                        elapsed_q <= 14'h0000;
                        BL_BUSY_O <= 1'b1;
                        state_q <= cmbc_pkg::ST_WAIT;
                     end
                  end
               cmbc_pkg::ST_WAIT:
                  if (ms_tick)
                  begin
                     ms_cnt_q <= 32'h0000_0000;
                     elapsed_q <= elapsed_q + 14'h0001;
                     div_start_q <= 1'b1;
                     state_q <= cmbc_pkg::ST_DIV;
                  end
                  else ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
               cmbc_pkg::ST_DIV:
               begin
                  ms_cnt_q <= ms_cnt_q + 32'h0000_0001; // keep the millisecond grid
                  if (div_done)
                  begin
                     // offset = start +/- amount * elapsed / time [RQ7]
                     BL_OFFSET_O <= goal_pos_q ? start_off_q + div_quot
                                               : start_off_q - div_quot;
                     // done only when the whole time has run [RQ8]
                     if ({2'b00, elapsed_q} == time_act_q)
                     begin
                        BL_BUSY_O <= 1'b0;
                        state_q <= cmbc_pkg::ST_IDLE;
                     end
                     else state_q <= cmbc_pkg::ST_WAIT;
                  end
               end
            endcase
         end
      end
   end

   // spreads the amount linearly over the processing time
   cmbc_divider u_div
   (
      .CORE_CLK_I(CORE_CLK_I),
      .RESET_N_I(RESET_N_I),
      .start_i(div_start_q),
      .dividend_i(45'(amount_act_q[30:0]) * 45'(elapsed_q)),
      .divisor_i(time_act_q[13:0]),
      .done_o(div_done),
      .quot_o(div_quot)
   );

   chk_edge_rise: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ1]
      (RELATIVE_MOVE_AFTER_CAPTURE_ENABLE_I && edge_q == cmbc_pkg::EDGE_RISE && cap_s2_q &&
       !cap_s3_q) |=> RELATIVE_MOVE_AFTER_CAPTURE_START_O)
      else $error("rising capture edge did not start the move");
   chk_edge_fall: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ1]
      (edge_q == cmbc_pkg::EDGE_FALL && cap_s2_q) |=> !RELATIVE_MOVE_AFTER_CAPTURE_START_O)
      else $error("start issued without a falling edge");
   chk_ovt_error: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ2] [RQ3]
      (ovt_hit && resp_q == cmbc_pkg::RESP_ERR_CLASS1) |=> OVT_ERROR_O && !OVT_RETURN_O)
      else $error("overshoot with response 0 raised no error");
   chk_ovt_return: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ2]
      (ovt_hit && resp_q == cmbc_pkg::RESP_RETURN) |=> OVT_RETURN_O ##1 !OVT_RETURN_O)
      else $error("overshoot with response 2 gave no single return pulse");
   chk_ovt_once: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ4]
      (ovt_hit ##1 RELATIVE_MOVE_AFTER_CAPTURE_MOVING_I) |=>
      !(OVT_ERROR_O || OVT_STOP_O || OVT_RETURN_O))
      else $error("overshoot reported twice in one move");
   chk_lock_amount: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ6]
      (PAR_WR_I && PAR_ADDR_I == cmbc_pkg::ADDR_BL_AMOUNT && POWER_EN_I)
      |=> PAR_ERR_O && $stable(amount_q))
      else $error("backlash amount changed while power stage enabled");
   chk_amount_sign: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ5]
      !amount_q[31])
      else $error("backlash amount went negative");
   chk_zero_time: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ7]
      (state_q == cmbc_pkg::ST_IDLE && reversal && !wr_mode && time_act_q == 16'h0000)
      |=> !BL_BUSY_O && BL_OFFSET_O != $past(BL_OFFSET_O) || amount_act_q == 32'h0000_0000)
      else $error("zero processing time did not apply at once");
   chk_full_time: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ8]
      (state_q == cmbc_pkg::ST_DIV && div_done && comp_on && !wr_mode &&
       {2'b00, elapsed_q} != time_act_q) |=> BL_BUSY_O)
      else $error("take-up ended before the processing time");
   chk_mode_off: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ9]
      (mode_q == cmbc_pkg::MODE_OFF) |=> BL_OFFSET_O == 32'h0000_0000 && !BL_BUSY_O)
      else $error("compensation active while mode is off");
   chk_op_mode: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I) // [RQ14]
      (state_q == cmbc_pkg::ST_IDLE && !opm_ok) |=> $stable(BL_OFFSET_O) || $past(wr_mode))
      else $error("compensation ran outside the allowed operating modes");
endmodule : cmbc_top

//--- tb/cmbc_load_model.sv
// Purpose: mechanical load behind the drive, position follows motion
// Assumes: one user unit of travel per clock while a move runs
// Notes: no inertia, so overshoot only depends on how long the move runs
module cmbc_load_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // motion command
   input wire logic move_i,
   input wire logic dir_pos_i,
   // actual position
   output logic [31:0] pos_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // position integrates while moving, so the mechanics really travel
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pos_o <= 32'h0000_0000;
      else if (move_i)
         pos_o <= dir_pos_i ? pos_o + 32'h1 : pos_o - 32'h1;
   end
endmodule : cmbc_load_model

//--- tb/cmbc_top_tb.sv
// Purpose: self-checking bench for capture move and backlash logic
// Assumes: parameter port answers one cycle after each strobe
// Notes: short millisecond keeps timed take-up runs brief
module cmbc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPM = 50; // cycles per ms, must stay above divider latency
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ack, err, start, o_err, o_stop, o_ret, busy;
   logic cap = 1'b0; // capture pin idles low
   logic rm_en = 1'b1;
   logic rm_mv = 1'b0;
   logic rdir = 1'b1; // travel direction of the relative move
   logic [31:0] tgt = 32'h0;
   logic [31:0] act;
   logic pwr = 1'b0;
   logic [3:0] opm = 4'h0;
   logic mact = 1'b0;
   logic mdir = 1'b1;
   logic [31:0] offs;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int n_start = 0;
   int n_busy = 0;
   int n_ovt [3] = '{0, 0, 0}; // pulses per overtravel response
   // free running clock
   always #2.5 clk = ~clk;
   cmbc_top #(.CYC_PER_MS(CPM)) DUT
   (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PAR_ADDR_I(addr), .PAR_WDATA_I(wdata),
      .PAR_WR_I(wr), .PAR_RD_I(rd), .PAR_RDATA_O(rdata), .PAR_ACK_O(ack), .PAR_ERR_O(err),
      .CAPTURE_I(cap), .RELATIVE_MOVE_AFTER_CAPTURE_ENABLE_I(rm_en),
      .RELATIVE_MOVE_AFTER_CAPTURE_MOVING_I(rm_mv), .ACT_POS_I(act),
      .TARGET_POS_I(tgt), .MOVE_DIR_POS_I(rdir), .RELATIVE_MOVE_AFTER_CAPTURE_START_O(start),
      .OVT_ERROR_O(o_err), .OVT_STOP_O(o_stop), .OVT_RETURN_O(o_ret),
      .POWER_EN_I(pwr), .OP_MODE_I(opm), .MOTION_ACTIVE_I(mact),
      .MOTION_DIR_POS_I(mdir), .BL_OFFSET_O(offs), .BL_BUSY_O(busy)
   );
   // load travels in the relative move's direction while that move runs
   cmbc_load_model LOAD (.clk_i(clk), .rst_n_i(rst_n), .move_i(rm_mv), .dir_pos_i(rdir),
      .pos_o(act));
   // pulse counters and the hang guard, on the falling edge where outputs are settled
   always @(negedge clk)
   begin
      cyc++;
      if (start === 1'b1) n_start++;
      if (busy === 1'b1) n_busy++;
      if (o_err === 1'b1) n_ovt[0]++;
      if (o_stop === 1'b1) n_ovt[1]++;
      if (o_ret === 1'b1) n_ovt[2]++;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok)
      begin
         $display("MISMATCH %0t %s", $time, msg);
         n_fail++;
      end
   endtask : chk
   // one strobe, answer sampled one cycle later
   task automatic wr_par(input logic [15:0] a, input logic [31:0] d, input logic e);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1;
      wr = 1'b0;
      chk(ack === 1'b1 && err === e, "write answer");
   endtask : wr_par
   // data is only compared when no refusal is expected
   task automatic rd_par(input logic [15:0] a, input logic [31:0] x, input logic e);
      @(posedge clk);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1;
      rd = 1'b0;
      chk(ack === 1'b1 && err === e && (e || rdata === x), "read answer");
   endtask : rd_par
   // move the pin, then count start pulses over the sync latency
   task automatic cap_to(input logic lvl, input int exp);
      int s;
      s = n_start;
      @(posedge clk);
      #1;
      cap = lvl;
      repeat (6) @(posedge clk);
      #1;
      chk(n_start - s == exp, "capture start count");
   endtask : cap_to
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   initial
   begin
      int snap [3];
      int nb;
      logic [3:0] ops [4];
      ops = '{cmbc_pkg::OPM_JOG, cmbc_pkg::OPM_PROFILE_POS, cmbc_pkg::OPM_INTERP_POS,
         cmbc_pkg::OPM_HOMING};
      settle(5);
      rst_n = 1'b1;
      // factory defaults and an unmapped place
      rd_par(cmbc_pkg::ADDR_BL_MODE, 32'h0, 1'b0);
      rd_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h0, 1'b0);
      rd_par(cmbc_pkg::ADDR_BL_TIME, 32'h0, 1'b0);
      rd_par(cmbc_pkg::ADDR_OVT_RESP, 32'h0, 1'b0);
      rd_par(cmbc_pkg::ADDR_CAP_EDGE, 32'h0, 1'b0);
      rd_par(16'h0700, 32'h0, 1'b1);
      // out of range values are refused and leave the old value
      wr_par(cmbc_pkg::ADDR_CAP_EDGE, 32'h2, 1'b1);
      wr_par(cmbc_pkg::ADDR_OVT_RESP, 32'h3, 1'b1);
      wr_par(cmbc_pkg::ADDR_BL_MODE, 32'h3, 1'b1);
      wr_par(cmbc_pkg::ADDR_BL_TIME, 32'h4000, 1'b1);
      wr_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h8000_0000, 1'b1);
      wr_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h7fff_ffff, 1'b0);
      rd_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h7fff_ffff, 1'b0);
      rd_par(cmbc_pkg::ADDR_BL_TIME, 32'h0, 1'b0);
      // capture edge selection, then a disarmed capture
      cap_to(1'b1, 0);
      cap_to(1'b0, 1);
      wr_par(cmbc_pkg::ADDR_CAP_EDGE, 32'h1, 1'b0);
      cap_to(1'b1, 1);
      cap_to(1'b0, 0);
      rm_en = 1'b0;
      cap_to(1'b1, 0);
      // each response setting picks its own output, one pulse per move;
      // the setting is written while the move already runs, before it overshoots
      for (int r = 0; r < 3; r++)
      begin
         snap = n_ovt;
         rdir = (r != 1); // middle run travels negative
         tgt = rdir ? act + 32'h4 : act - 32'h4;
         rm_mv = 1'b1;
         wr_par(cmbc_pkg::ADDR_OVT_RESP, 32'(r), 1'b0);
         settle(10);
         rm_mv = 1'b0;
         settle(2);
         for (int k = 0; k < 3; k++)
            chk(n_ovt[k] - snap[k] == int'(k == r), "overtravel pulses");
      end
      // immediate take-up with amounts latched at power enable
      wr_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h5, 1'b0);
      pwr = 1'b1;
      wr_par(cmbc_pkg::ADDR_BL_AMOUNT, 32'h9, 1'b1);
      wr_par(cmbc_pkg::ADDR_BL_TIME, 32'h1, 1'b1);
      mact = 1'b1; // positive movement before mode 1 is selected
      for (int i = 0; i < 4; i++)
      begin
         wr_par(cmbc_pkg::ADDR_BL_MODE, 32'h1, 1'b0);
         opm = ops[i];
         mdir = 1'b0;
         settle(3);
         chk(offs === 32'hffff_fffb, "negative reversal");
         mdir = 1'b1;
         settle(3);
         chk(offs === 32'h0, "positive reversal");
      end
      opm = 4'h5; // no compensation in other operating modes
      mdir = 1'b0;
      settle(3);
      chk(offs === 32'h0, "mode without compensation");
      opm = cmbc_pkg::OPM_JOG;
      wr_par(cmbc_pkg::ADDR_BL_MODE, 32'h2, 1'b0); // after negative movement
      mdir = 1'b1;
      settle(3);
      chk(offs === 32'h5, "after negative movement");
      wr_par(cmbc_pkg::ADDR_BL_MODE, 32'h0, 1'b0);
      settle(2);
      chk(offs === 32'h0, "compensation off");
      // timed take-up of 2 ms, new time only after the next enable
      pwr = 1'b0;
      wr_par(cmbc_pkg::ADDR_BL_TIME, 32'h2, 1'b0);
      pwr = 1'b1;
      wr_par(cmbc_pkg::ADDR_BL_MODE, 32'h1, 1'b0);
      nb = n_busy;
      mdir = 1'b0;
      settle(3);
      chk(busy === 1'b1 && offs !== 32'hffff_fffb, "take-up spread");
      for (int w = 0; w < 600 && busy !== 1'b0; w++) settle(1);
      chk(busy === 1'b0 && n_busy - nb >= 2 * CPM, "take-up duration");
      chk(offs === 32'hffff_fffb, "take-up end value");
      close_out();
   end
endmodule : cmbc_top_tb
